/* hdl/sadc_top.sv */
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module sadc_cache #(
  parameter bit IS_DATA = 1'b1
) (
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  // Core side
  input  sadc_pkg::sadc_cpu_req_t     req_in,
  output sadc_pkg::sadc_cpu_rsp_t     rsp_out,
  // Internal bus side
  output sadc_pkg::sadc_bus_req_t     bus_out,
  input  sadc_pkg::sadc_bus_rsp_t     bus_in,
  // Control
  input  wire logic                   enable_in,
  input  wire logic                   half_lock_in,
  input  wire logic                   inval_req_in,
  input  wire logic                   fbuf_en_in,
  input  wire logic                   defer_en_in,
  output logic                        inval_done_out,
  output logic                        busy_out
);
  import sadc_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_FILL, ST_SINGLE, ST_PUSH, ST_INVAL} sadc_state_t;

  sadc_state_t state_q;
  logic [TAG_W-1:0] tag_mem   [SETS][WAYS];
  logic [WAYS-1:0]  valid_mem [SETS];
  logic [WAYS-1:0]  mod_mem   [SETS];
  logic [31:0]      data_mem  [SETS][WAYS][WORDS];

  logic [IDX_W-1:0] idx;
  logic [TAG_W-1:0] tg;
  logic [1:0]       wsel;
  logic [WAYS-1:0]  hit_vec;
  logic             hit;
  logic [1:0]       hit_way;
  logic [1:0]       victim;
  logic             all_valid;
  logic             cacheable;
  logic             fbuf_ok;
  logic             fb_hit;
  logic             acc;
  logic             rd_hit_go;
  logic             wr_hit_go;
  logic             alloc_go;
  logic             fb_fill_go;
  logic             ext_wr_go;
  logic             ext_rd_go;
  logic             defer_go;
  logic             hit_ok;
  logic [1:0]       repl_q;

  // Fill context
  logic [IDX_W-1:0] f_idx_q;
  logic [1:0]       f_way_q;
  logic [TAG_W-1:0] f_tag_q;
  logic [1:0]       f_crit_q;
  logic [1:0]       beat_q;
  logic             f_write_q;
  logic             f_fbuf_q;
  logic [3:0]       f_be_q;
  logic [31:0]      f_wdata_q;
  logic [1:0]       fw;
  logic [31:0]      fill_word;
  logic             fill_done;

  // Single transfer context
  logic [31:0]      s_addr_q;
  logic             s_write_q;
  logic [3:0]       s_be_q;
  logic [31:0]      s_wdata_q;

  // Push buffer
  logic [31:0]      pb_addr_q [PB_DEPTH];
  logic [31:0]      pb_data_q [PB_DEPTH];
  logic [3:0]       pb_be_q   [PB_DEPTH];
  logic [2:0]       pb_cnt_q;
  logic [1:0]       pb_ptr_q;

  // Fill buffer
  logic             fbuf_v_q;
  logic [27:0]      fbuf_line_q;
  logic [31:0]      fbuf_data_q [WORDS];

  logic [IDX_W-1:0] inv_cnt_q;
  logic             rvalid_q;
  logic [31:0]      rdata_q;

  assign idx  = req_in.addr[IDX_MSB:IDX_LSB];
  assign tg   = req_in.addr[31:TAG_LSB];
  assign wsel = req_in.addr[3:2];

  always_comb begin
    hit_vec   = '0;
    hit_way   = 2'h0;
    victim    = 2'h0;
    all_valid = &valid_mem[idx];
    for (int w = WAYS - 1; w >= 0; w--) begin
      hit_vec[w] = valid_mem[idx][w] && (tag_mem[idx][w] == tg);
      if (hit_vec[w]) begin
        hit_way = w[1:0];
      end
      if (!valid_mem[idx][w]) begin
        victim = w[1:0];
      end
    end
    if (all_valid) begin
      victim = half_lock_in ? {1'b1, repl_q[0]} : repl_q;
    end
  end

  assign hit       = |hit_vec;
  assign cacheable = enable_in && (req_in.mode != MODE_INHIBIT);
  assign fbuf_ok   = !IS_DATA && fbuf_en_in && (req_in.ttype == TT_NORMAL);
  assign fb_hit    = fbuf_ok && fbuf_v_q && (fbuf_line_q == req_in.addr[31:4]);

  // In fill or push only bus-free hits, after the critical word, so answers never clash
  assign hit_ok = req_in.valid && (state_q == ST_FILL ? beat_q != 2'h0 : 1'b1) &&
                  (req_in.write ? (!IS_DATA ||
                                   (cacheable && hit && req_in.mode == MODE_CBACK))
                                : ((cacheable && hit) || (!cacheable && fb_hit)));

  always_comb begin
    rsp_out        = '0;
    rsp_out.rvalid = rvalid_q;
    rsp_out.rdata  = rdata_q;
    unique case (state_q)
      ST_IDLE:         rsp_out.ready = !inval_req_in;
      ST_FILL, ST_PUSH: rsp_out.ready = hit_ok;
      default:         rsp_out.ready = 1'b0;
    endcase
  end

  assign acc        = req_in.valid && rsp_out.ready;
  assign rd_hit_go  = acc && !req_in.write && cacheable && hit;
  assign wr_hit_go  = acc && req_in.write && IS_DATA && cacheable && hit;
  assign alloc_go   = acc && (state_q == ST_IDLE) && cacheable && !hit &&
                      (!req_in.write || (IS_DATA && req_in.mode == MODE_CBACK));
  assign fb_fill_go = acc && (state_q == ST_IDLE) && !req_in.write && !cacheable &&
                      fbuf_ok && !fb_hit;
  assign ext_wr_go  = acc && (state_q == ST_IDLE) && req_in.write && IS_DATA &&
                      (!cacheable || req_in.mode == MODE_WTHRU);
  assign ext_rd_go  = acc && (state_q == ST_IDLE) && !req_in.write && !cacheable &&
                      !fbuf_ok;
  assign defer_go   = ext_wr_go && defer_en_in && (pb_cnt_q == 3'h0);

  assign fw        = f_crit_q + beat_q;
  assign fill_done = (state_q == ST_FILL) && bus_in.ack && (beat_q == 2'h3);
  always_comb begin
    fill_word = bus_in.rdata;
    if (f_write_q && fw == f_crit_q) begin
      for (int b = 0; b < 4; b++) begin
        if (f_be_q[b]) begin
          fill_word[8*b +: 8] = f_wdata_q[8*b +: 8];
        end
      end
    end
  end

  always_comb begin
    bus_out = '0;
    unique case (state_q)
      ST_FILL: begin
        bus_out.valid = 1'b1;
        bus_out.burst = 1'b1;
        bus_out.be    = 4'hf;
        bus_out.addr  = {f_tag_q, f_idx_q, f_crit_q, 2'h0};
      end
      ST_SINGLE: begin
        bus_out.valid = 1'b1;
        bus_out.write = s_write_q;
        bus_out.be    = s_be_q;
        bus_out.addr  = s_addr_q;
        bus_out.wdata = s_wdata_q;
      end
      ST_PUSH: begin
        bus_out.valid = 1'b1;
        bus_out.write = 1'b1;
        bus_out.be    = pb_be_q[pb_ptr_q];
        bus_out.addr  = pb_addr_q[pb_ptr_q];
        bus_out.wdata = pb_data_q[pb_ptr_q];
      end
      default: bus_out = '0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (inval_req_in) begin
            state_q <= ST_INVAL;
          end else if (alloc_go || fb_fill_go) begin
            state_q <= ST_FILL;
          end else if (defer_go) begin
            state_q <= ST_PUSH;
          end else if (ext_wr_go || ext_rd_go) begin
            state_q <= ST_SINGLE;
          end
        end
        ST_FILL: begin
          if (fill_done) begin
            state_q <= (pb_cnt_q != 3'h0) ? ST_PUSH : ST_IDLE;
          end
        end
        ST_SINGLE: begin
          if (bus_in.ack) begin
            state_q <= ST_IDLE;
          end
        end
        ST_PUSH: begin
          if (bus_in.ack && ({1'b0, pb_ptr_q} == pb_cnt_q - 3'h1)) begin
            state_q <= ST_IDLE;
          end
        end
        ST_INVAL: begin
          if (inv_cnt_q == IDX_W'(SETS - 1)) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      inv_cnt_q <= '0;
    end else if (state_q == ST_INVAL) begin
      inv_cnt_q <= inv_cnt_q + IDX_W'(1);
    end else begin
      inv_cnt_q <= '0;
    end
  end
  assign inval_done_out = (state_q == ST_INVAL) && (inv_cnt_q == IDX_W'(SETS - 1));
  assign busy_out       = (state_q == ST_INVAL);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      repl_q <= 2'h0;
    end else if (alloc_go) begin
      repl_q <= repl_q + 2'h1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      f_idx_q   <= '0;
      f_way_q   <= 2'h0;
      f_tag_q   <= '0;
      f_crit_q  <= 2'h0;
      f_write_q <= 1'b0;
      f_fbuf_q  <= 1'b0;
      f_be_q    <= 4'h0;
      f_wdata_q <= 32'h0;
    end else if (alloc_go || fb_fill_go) begin
      f_idx_q   <= idx;
      f_way_q   <= victim;
      f_tag_q   <= tg;
      f_crit_q  <= wsel;
      f_write_q <= req_in.write;
      f_fbuf_q  <= fb_fill_go;
      f_be_q    <= req_in.be;
      f_wdata_q <= req_in.wdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      beat_q <= 2'h0;
    end else if (state_q == ST_FILL && bus_in.ack) begin
      beat_q <= beat_q + 2'h1;
    end else if (state_q != ST_FILL) begin
      beat_q <= 2'h0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_addr_q  <= 32'h0;
      s_write_q <= 1'b0;
      s_be_q    <= 4'h0;
      s_wdata_q <= 32'h0;
    end else if ((ext_wr_go && !defer_go) || ext_rd_go) begin
      s_addr_q  <= req_in.addr;
      s_write_q <= req_in.write;
      s_be_q    <= req_in.be;
      s_wdata_q <= req_in.wdata;
    end
  end

  // Line flags keep their state through reset
  always_ff @(posedge clk_in) begin
    if (state_q == ST_INVAL) begin
      valid_mem[inv_cnt_q] <= '0;
    end else begin
      if (alloc_go) begin
        valid_mem[idx][victim] <= 1'b0;
      end
      if (fill_done && !f_fbuf_q) begin
        valid_mem[f_idx_q][f_way_q] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (state_q == ST_INVAL) begin
      mod_mem[inv_cnt_q] <= '0;
    end else begin
      if (alloc_go) begin
        mod_mem[idx][victim] <= 1'b0;
      end
      if (wr_hit_go && req_in.mode == MODE_CBACK) begin
        mod_mem[idx][hit_way] <= 1'b1;
      end
      if (fill_done && !f_fbuf_q && f_write_q) begin
        mod_mem[f_idx_q][f_way_q] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (alloc_go) begin
      tag_mem[idx][victim] <= tg;
    end
  end

  always_ff @(posedge clk_in) begin
    if (wr_hit_go) begin
      for (int b = 0; b < 4; b++) begin
        if (req_in.be[b]) begin
          data_mem[idx][hit_way][wsel][8*b +: 8] <= req_in.wdata[8*b +: 8];
        end
      end
    end
    if (state_q == ST_FILL && bus_in.ack && !f_fbuf_q) begin
      data_mem[f_idx_q][f_way_q][fw] <= fill_word;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fbuf_v_q    <= 1'b0;
      fbuf_line_q <= '0;
    end else if (state_q == ST_INVAL || fb_fill_go) begin
      fbuf_v_q <= 1'b0;
      if (fb_fill_go) begin
        fbuf_line_q <= req_in.addr[31:4];
      end
    end else if (fill_done && f_fbuf_q) begin
      fbuf_v_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (state_q == ST_FILL && bus_in.ack && f_fbuf_q) begin
      fbuf_data_q[fw] <= bus_in.rdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pb_cnt_q <= 3'h0;
      pb_ptr_q <= 2'h0;
    end else if (alloc_go && IS_DATA && valid_mem[idx][victim] && mod_mem[idx][victim]) begin
      pb_cnt_q <= 3'(PB_DEPTH);
      pb_ptr_q <= 2'h0;
    end else if (defer_go) begin
      pb_cnt_q <= 3'h1;
      pb_ptr_q <= 2'h0;
    end else if (state_q == ST_PUSH && bus_in.ack) begin
      if ({1'b0, pb_ptr_q} == pb_cnt_q - 3'h1) begin
        pb_cnt_q <= 3'h0;
        pb_ptr_q <= 2'h0;
      end else begin
        pb_ptr_q <= pb_ptr_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (alloc_go) begin
      for (int i = 0; i < PB_DEPTH; i++) begin
        pb_data_q[i] <= data_mem[idx][victim][i];
        pb_addr_q[i] <= {tag_mem[idx][victim], idx, i[1:0], 2'h0};
        pb_be_q[i]   <= 4'hf;
      end
    end else if (defer_go) begin
      pb_data_q[0] <= req_in.wdata;
      pb_addr_q[0] <= req_in.addr;
      pb_be_q[0]   <= req_in.be;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
    end else begin
      rvalid_q <= 1'b0;
      if (rd_hit_go) begin
        rvalid_q <= 1'b1;
        rdata_q  <= data_mem[idx][hit_way][wsel];
      end else if (acc && !req_in.write && !cacheable && fb_hit) begin
        rvalid_q <= 1'b1;
        rdata_q  <= fbuf_data_q[wsel];
      end else if (state_q == ST_FILL && bus_in.ack && beat_q == 2'h0 && !f_write_q) begin
        rvalid_q <= 1'b1;
        rdata_q  <= bus_in.rdata;
      end else if (state_q == ST_SINGLE && bus_in.ack && !s_write_q) begin
        rvalid_q <= 1'b1;
        rdata_q  <= bus_in.rdata;
      end
    end
  end
endmodule

module sadc_top (
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  // Register port
  input  wire logic [7:0]             reg_addr_in,
  input  wire logic [31:0]            reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output logic [31:0]                 reg_rdata_out,
  // Instruction side
  input  sadc_pkg::sadc_cpu_req_t     instr_req_in,
  output sadc_pkg::sadc_cpu_rsp_t     instr_rsp_out,
  output sadc_pkg::sadc_bus_req_t     instr_bus_out,
  input  sadc_pkg::sadc_bus_rsp_t     instr_bus_in,
  // Data side
  input  sadc_pkg::sadc_cpu_req_t     data_req_in,
  output sadc_pkg::sadc_cpu_rsp_t     data_rsp_out,
  output sadc_pkg::sadc_bus_req_t     data_bus_out,
  input  sadc_pkg::sadc_bus_rsp_t     data_bus_in,
  // Branch cache enable level
  output logic                        branch_cache_enable_out
);
  import sadc_pkg::*;

  logic [31:0] cache_control_reg_q;
  logic        d_done;
  logic        i_done;
  logic        d_busy;
  logic        i_busy;
  logic        ctrl_wr;

  assign ctrl_wr = reg_wr_in && (reg_addr_in == CTRL_OFS);

  // A write in the sweep's last cycle wins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cache_control_reg_q <= CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        cache_control_reg_q <= reg_wdata_in;
      end
      if (d_done && !(ctrl_wr && reg_wdata_in[CB_DATA_INVA])) begin
        cache_control_reg_q[CB_DATA_INVA] <= 1'b0;
      end
      if (i_done && !(ctrl_wr && reg_wdata_in[CB_INSTR_INVA])) begin
        cache_control_reg_q[CB_INSTR_INVA] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0;
    end else if (reg_rd_in && reg_addr_in == CTRL_OFS) begin
      reg_rdata_out <= cache_control_reg_q;
    end else if (reg_rd_in && reg_addr_in == STATUS_OFS) begin
      reg_rdata_out <= 32'h0;
      reg_rdata_out[SB_DATA_BUSY]  <= d_busy;
      reg_rdata_out[SB_INSTR_BUSY] <= i_busy;
    end else begin
      reg_rdata_out <= 32'h0;
    end
  end

  assign branch_cache_enable_out = cache_control_reg_q[CB_BRANCH_EN];

  sadc_cache #(.IS_DATA(1'b1)) u_data (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .req_in        (data_req_in),
    .rsp_out       (data_rsp_out),
    .bus_out       (data_bus_out),
    .bus_in        (data_bus_in),
    .enable_in     (cache_control_reg_q[CB_DATA_EN]),
    .half_lock_in  (cache_control_reg_q[CB_DATA_HLCK]),
    .inval_req_in  (cache_control_reg_q[CB_DATA_INVA]),
    .fbuf_en_in    (1'b0),
    .defer_en_in   (cache_control_reg_q[CB_DEFER_EN]),
    .inval_done_out(d_done),
    .busy_out      (d_busy)
  );

  sadc_cache #(.IS_DATA(1'b0)) u_instr (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .req_in        (instr_req_in),
    .rsp_out       (instr_rsp_out),
    .bus_out       (instr_bus_out),
    .bus_in        (instr_bus_in),
    .enable_in     (cache_control_reg_q[CB_INSTR_EN]),
    .half_lock_in  (cache_control_reg_q[CB_INSTR_HLCK]),
    .inval_req_in  (cache_control_reg_q[CB_INSTR_INVA]),
    .fbuf_en_in    (cache_control_reg_q[CB_FBUF_EN]),
    .defer_en_in   (1'b0),
    .inval_done_out(i_done),
    .busy_out      (i_busy)
  );
endmodule

/* include/sadc_pkg.sv */
// Overview of operation
// - Separate 32K four-way nonblocking instruction/data caches
// - Each cache has 512 sets of four ways
// - Line valid only after four-longword burst completes
// - Set index is address bits 12..4
// - Hit needs tag match on bits 31..13 plus valid
// - Copyback write hit: merge bytes, set modified, no bus
// - Write-through hit: update line and write externally
// - Allocate first invalid way, way 0 first
// - All valid: two-bit counter picks victim, then advances
// - Half lock limits replacement in a fully valid set to ways 2 and 3
// - Modified victim goes to push buffer, written after fill
// - Four-entry 32-bit push buffer, optional write deferral
// - Allocation writes tag, loads data, sets valid
// - Read and copyback write misses allocate; write-through not
// - Copyback write miss fills, merges, sets valid and modified
// - Read hit changes no flags, no replacement
// - Inhibited writes go straight to external bus
// - Inhibited instruction read may use line fill buffer
// - Inhibited access never pushes or invalidates matching lines
// - Read and copyback write hits still served while a fill runs
// - Instruction cache ignores writes; data lines have three states
// - Reset keeps line flags; software invalidates all before use
// - Critical longword fetched first and returned at once
// - Reset disables both caches, clears control register
package sadc_pkg;
  localparam int SETS     = 512;
  localparam int WAYS     = 4;
  localparam int WORDS    = 4;
  localparam int IDX_LSB  = 4;
  localparam int IDX_MSB  = 12;
  localparam int TAG_LSB  = 13;
  localparam int TAG_W    = 32 - TAG_LSB;
  localparam int IDX_W    = IDX_MSB - IDX_LSB + 1;
  localparam int PB_DEPTH = 4;
  localparam int REG_AW   = 8;

  localparam logic [1:0] MODE_INHIBIT = 2'h0;
  localparam logic [1:0] MODE_WTHRU   = 2'h1;
  localparam logic [1:0] MODE_CBACK   = 2'h2;
  localparam logic [1:0] TT_NORMAL    = 2'h0;

  localparam logic [REG_AW-1:0] CTRL_OFS   = 8'h00;
  localparam logic [REG_AW-1:0] STATUS_OFS = 8'h04;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CB_DATA_EN    = 0;
  localparam int CB_DATA_INVA  = 1;
  localparam int CB_DATA_HLCK  = 2;
  localparam int CB_DEFER_EN   = 3;
  localparam int CB_INSTR_EN   = 8;
  localparam int CB_INSTR_INVA = 9;
  localparam int CB_INSTR_HLCK = 10;
  localparam int CB_FBUF_EN    = 11;
  localparam int CB_BRANCH_EN  = 12;
  localparam int SB_DATA_BUSY  = 0;
  localparam int SB_INSTR_BUSY = 1;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        write;
    logic [3:0]  be;
    logic [31:0] wdata;
    logic [1:0]  mode;
    logic [1:0]  ttype;
  } sadc_cpu_req_t;

  typedef struct packed {
    logic        ready;
    logic        rvalid;
    logic [31:0] rdata;
  } sadc_cpu_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        write;
    logic        burst;
    logic [3:0]  be;
    logic [31:0] wdata;
  } sadc_bus_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } sadc_bus_rsp_t;
endpackage

/* tb/sadc_checker.sv */
`timescale 1ns/1ns
module sadc_checker (
  // Clock and reset
  input wire logic               clk_in,
  input wire logic               rst_in,
  // Watched ports
  input sadc_pkg::sadc_cpu_req_t data_req_in,
  input sadc_pkg::sadc_cpu_rsp_t data_rsp_out,
  input sadc_pkg::sadc_bus_req_t data_bus_out,
  input sadc_pkg::sadc_bus_rsp_t data_bus_in,
  input sadc_pkg::sadc_bus_req_t instr_bus_out,
  input wire logic               branch_cache_enable_out
);
  import sadc_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [2:0]  beats_q;
  logic        pend_wr_q;
  logic [31:0] wt_addr_q;
  always_ff @(posedge clk_in) begin
    if (rst_in || !(data_bus_out.valid && data_bus_out.burst)) begin
      beats_q <= 3'h0;
    end else if (data_bus_in.ack) begin
      beats_q <= beats_q + 3'h1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pend_wr_q <= 1'b0;
      wt_addr_q <= 32'h0;
    end else if (data_req_in.valid && data_rsp_out.ready) begin
      pend_wr_q <= data_req_in.write;
      wt_addr_q <= data_req_in.addr;
    end
  end
  a_reset_clears: assert property ($fell(rst_in) |->
    !branch_cache_enable_out && !data_bus_out.valid && !data_rsp_out.rvalid)
    else $error("active after reset");
  a_burst_len: assert property (data_bus_out.valid && data_bus_out.burst |-> beats_q < 3'h4)
    else $error("burst over four beats");
  a_burst_whole: assert property (data_bus_out.valid && data_bus_out.burst && data_bus_in.ack
    && beats_q < 3'h3 |=> data_bus_out.valid && data_bus_out.burst)
    else $error("burst ended early");
  a_req_held: assert property (data_bus_out.valid && !data_bus_in.ack |=> data_bus_out.valid
    && $stable(data_bus_out.addr) && $stable(data_bus_out.write))
    else $error("bus request changed before ack");
  a_crit_first: assert property (data_bus_out.valid && data_bus_out.burst && data_bus_in.ack
    && beats_q == 3'h0 && !pend_wr_q |=> data_rsp_out.rvalid
    && data_rsp_out.rdata == $past(data_bus_in.rdata))
    else $error("critical word late");
  a_thru_write: assert property (data_req_in.valid && data_rsp_out.ready && data_req_in.write
    && data_req_in.mode != MODE_CBACK |-> ##[1:60] (data_bus_out.valid && data_bus_out.write
    && !data_bus_out.burst && data_bus_out.addr[31:2] == wt_addr_q[31:2]))
    else $error("write not on bus");
  a_instr_no_write: assert property (instr_bus_out.valid |-> !instr_bus_out.write)
    else $error("instruction bus write");
  a_rvalid_cause: assert property (data_rsp_out.rvalid |-> $past(data_bus_in.ack)
    || ($past(data_req_in.valid) && $past(data_rsp_out.ready)))
    else $error("stray read answer");
endmodule
bind sadc_top sadc_checker i_sadc_checker (.clk_in(clk_in), .rst_in(rst_in),
  .data_req_in(data_req_in), .data_rsp_out(data_rsp_out), .data_bus_out(data_bus_out),
  .data_bus_in(data_bus_in), .instr_bus_out(instr_bus_out),
  .branch_cache_enable_out(branch_cache_enable_out));

/* tb/sadc_mem_model.sv */
`timescale 1ns/1ns
module sadc_mem_model (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  // Cache bus port
  input  sadc_pkg::sadc_bus_req_t req_in,
  output sadc_pkg::sadc_bus_rsp_t rsp_out,
  // Wait states before each ack
  input  wire logic [1:0]         wait_in
);
  import sadc_pkg::*;
  logic [1:0] wait_q;
  logic [1:0] beat_q;
  // Gap after each ack
  always_ff @(posedge clk_in) begin
    rsp_out.ack   <= 1'b0;
    rsp_out.rdata <= rst_in ? 32'h0 : ~rsp_out.rdata;
    if (rst_in || !req_in.valid) begin
      wait_q <= 2'h0;
      beat_q <= 2'h0;
    end else if (!rsp_out.ack) begin
      if (wait_q != wait_in) begin
        wait_q <= wait_q + 2'h1;
      end else begin
        wait_q        <= 2'h0;
        beat_q        <= beat_q + 2'h1;
        rsp_out.ack   <= 1'b1;
        rsp_out.rdata <= ~{req_in.addr[31:4], req_in.addr[3:2] + beat_q, 2'h0};
      end
    end
  end
endmodule

/* tb/testbench.sv */
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
  import sadc_pkg::*;
  logic          clk_in   = 1'b0;
  logic          rst_in   = 1'b1;
  logic [7:0]    ra       = 8'h00;
  logic [31:0]   rw       = 32'h0;
  logic          rwr      = 1'b0;
  logic          rrd      = 1'b0;
  logic [1:0]    wt       = 2'h0;
  logic [31:0]   rd, a, v;
  logic          bce;
  sadc_cpu_req_t ireq     = '0;
  sadc_cpu_req_t dreq     = '0;
  sadc_cpu_rsp_t irsp, drsp;
  sadc_bus_req_t ibo, dbo;
  sadc_bus_rsp_t ibi, dbi;
  int            failures = 0;
  int            n_tests  = 0;
  int            nb = 0, nw = 0, ni = 0, k, n0, n1;
  sadc_top i_sadc_top (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(ra), .reg_wdata_in(rw),
    .reg_wr_in(rwr), .reg_rd_in(rrd), .reg_rdata_out(rd), .instr_req_in(ireq),
    .instr_rsp_out(irsp), .instr_bus_out(ibo), .instr_bus_in(ibi), .data_req_in(dreq),
    .data_rsp_out(drsp), .data_bus_out(dbo), .data_bus_in(dbi), .branch_cache_enable_out(bce));
  sadc_mem_model i_sadc_mem_model_i (.clk_in(clk_in), .rst_in(rst_in), .req_in(ibo),
    .rsp_out(ibi), .wait_in(wt));
  sadc_mem_model i_sadc_mem_model_d (.clk_in(clk_in), .rst_in(rst_in), .req_in(dbo),
    .rsp_out(dbi), .wait_in(wt));
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  // Bus beats seen
  always @(posedge clk_in) begin
    if (dbo.valid && dbi.ack) begin
      nb <= nb + int'(dbo.burst);
      nw <= nw + int'(dbo.write);
    end
    if (ibo.valid && ibi.ack && ibo.burst) begin
      ni <= ni + 1;
    end
  end
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic lim(input int c);
    if (c >= 1000) begin
      failures++;
      tally_and_finish();
    end
  endtask
  task automatic reg_op(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_in);
    ra  <= ad;
    rw  <= d;
    rwr <= w;
    rrd <= !w;
    @(posedge clk_in);
    rwr <= 1'b0;
    rrd <= 1'b0;
    @(negedge clk_in);
    v = rd;
  endtask
  task automatic cpu(input bit i, input logic [31:0] ad, input logic w, input logic [31:0] d,
                     input logic [1:0] md, tt);
    sadc_cpu_req_t r;
    r = '{1'b1, ad, w, 4'hf, d, md, tt};
    @(posedge clk_in);
    if (i) ireq <= r;
    else dreq <= r;
    k = 0;
    do begin
      @(negedge clk_in);
      k++;
    end while ((i ? irsp.ready : drsp.ready) !== 1'b1 && k < 1000);
    lim(k);
    @(posedge clk_in);
    ireq.valid <= 1'b0;
    dreq.valid <= 1'b0;
    if (!w) begin
      k = 0;
      do begin
        @(negedge clk_in);
        k++;
      end while ((i ? irsp.rvalid : drsp.rvalid) !== 1'b1 && k < 1000);
      lim(k);
      v = i ? irsp.rdata : drsp.rdata;
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  initial begin
    void'($urandom(32'h7f18));
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    reg_op(1'b0, CTRL_OFS, 32'h0);
    `CHK("ctrl", CTRL_RESET, v)
    `CHK("branch", 1'b0, bce)
    reg_op(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, v)
    reg_op(1'b1, CTRL_OFS, 32'h202);
    n0 = 0;
    do begin
      reg_op(1'b0, STATUS_OFS, 32'h0);
      n0++;
    end while (v[1:0] !== 2'h0 && n0 < 1000);
    lim(n0);
    reg_op(1'b1, CTRL_OFS, 32'h1901);
    reg_op(1'b0, CTRL_OFS, 32'h0);
    `CHK("enable", 32'h1901, v)
    `CHK("branch", 1'b1, bce)
    done("registers");
    // First line after the sweep lands in way 0
    a = 32'h1230;
    n0 = nb;
    cpu(1'b0, a, 1'b0, 32'h0, MODE_CBACK, TT_NORMAL);
    `CHK("miss", ~a, v)
    cpu(1'b0, a + 32'h4, 1'b0, 32'h0, MODE_CBACK, TT_NORMAL);
    `CHK("hit", ~(a + 32'h4), v)
    `CHK("hit fills", n0 + 4, nb)
    n1 = nw;
    cpu(1'b0, a, 1'b1, 32'hcafe0001, MODE_CBACK, TT_NORMAL);
    cpu(1'b0, a, 1'b0, 32'h0, MODE_CBACK, TT_NORMAL);
    `CHK("cb hit", 32'hcafe0001, v)
    `CHK("cb no bus", n1, nw)
    cpu(1'b0, a + 32'h8, 1'b1, 32'h11112222, MODE_WTHRU, TT_NORMAL);
    cpu(1'b0, a + 32'h8, 1'b0, 32'h0, MODE_WTHRU, TT_NORMAL);
    `CHK("wt hit", 32'h11112222, v)
    `CHK("wt bus", n1 + 1, nw)
    n0 = nb;
    cpu(1'b0, 32'h3230, 1'b1, 32'h77, MODE_WTHRU, TT_NORMAL);
    cpu(1'b0, 32'h3230, 1'b0, 32'h0, MODE_WTHRU, TT_NORMAL);
    `CHK("wt miss", n0 + 1, nb)
    n1 = nw;
    cpu(1'b0, 32'h5240, 1'b1, 32'h5555aaaa, MODE_CBACK, TT_NORMAL);
    cpu(1'b0, 32'h5240, 1'b0, 32'h0, MODE_CBACK, TT_NORMAL);
    `CHK("cb miss", 32'h5555aaaa, v)
    `CHK("cb miss bus", n1, nw)
    done("write policies");
    for (int i = 1; i < 4; i++) begin
      cpu(1'b0, a + 32'h2000 * i, 1'b1, 32'(i), MODE_CBACK, TT_NORMAL);
    end
    n1 = nw;
    cpu(1'b0, a + 32'h8000, 1'b0, 32'h0, MODE_CBACK, TT_NORMAL);
    `CHK("evict fill", ~(a + 32'h8000), v)
    `CHK("push after fill", n1, nw)
    for (k = 0; k < 1000 && nw < n1 + 4; k++) @(negedge clk_in);
    lim(k);
    `CHK("push beats", n1 + 4, nw)
    done("eviction");
    n0 = ni;
    cpu(1'b1, 32'h7700, 1'b0, 32'h0, MODE_INHIBIT, TT_NORMAL);
    `CHK("fbuf fill", ~32'h7700, v)
    cpu(1'b1, 32'h7704, 1'b0, 32'h0, MODE_INHIBIT, TT_NORMAL);
    `CHK("fbuf hit", ~32'h7704, v)
    cpu(1'b1, 32'h9708, 1'b0, 32'h0, MODE_INHIBIT, 2'h1);
    `CHK("inhibit read", ~32'h9708, v)
    `CHK("fbuf bursts", n0 + 4, ni)
    done("fill buffer");
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_in);
      wt <= 2'($urandom);
      a = {1'b1, 29'($urandom), 2'h0};
      cpu(1'b0, a, 1'b0, 32'h0, 2'($urandom % 3), TT_NORMAL);
      `CHK("random read", ~a, v)
    end
    done("random reads");
    tally_and_finish();
  end
endmodule
